// ---- common/umd_regs.svh ----
// Register offsets, field positions, reset values and trigger depths of the modem, DMA and pin logic.
// Assumes a 4-bit register address with data in the low eight bits of each register.
`ifndef UMD_REGS_SVH
`define UMD_REGS_SVH

// Register offsets.
`define UMD_OFS_DATA      4'h0
`define UMD_OFS_IRQ_MASK  4'h1
`define UMD_OFS_FIFO_CTL  4'h2
`define UMD_OFS_MODEM_CTL 4'h4
`define UMD_OFS_MODEM_STS 4'h6
`define UMD_OFS_IRQ_STS   4'h8
`define UMD_OFS_LEVELS    4'h9

// Field positions.
`define UMD_FCR_FIFO_EN   0
`define UMD_FCR_RX_CLR    1
`define UMD_FCR_TX_CLR    2
`define UMD_FCR_DMA_SEL   3
`define UMD_FCR_TRIG_LO   6
`define UMD_FCR_TRIG_HI   7
`define UMD_MCR_RTS       1
`define UMD_MCR_LOOP      4
`define UMD_MSR_RING_EDGE 2
`define UMD_MSR_RING      6
`define UMD_IRQ_MODEM     0
`define UMD_IRQ_RX        1
`define UMD_IRQ_TX_EMPTY  2

// Reset values.
`define UMD_RST_FIFO_CTL  8'h00
`define UMD_RST_MODEM_CTL 8'h00
`define UMD_RST_IRQ_MASK  3'h0

// Receive trigger depths selected by the two trigger bits.
`define UMD_TRIG_0        8'h01
`define UMD_TRIG_1        8'h04
`define UMD_TRIG_2        8'h08
`define UMD_TRIG_3        8'h0e

`endif

// ---- common/umd_pkg.sv ----
// Types shared by the modem, DMA and pin logic.
// Assumes the offsets and fields come from umd_regs.svh.
package umd_pkg;
   typedef logic [7:0] umd_byte_t;
   typedef enum logic {UMD_DMA_SINGLE, UMD_DMA_MULTI} umd_dma_mode_t;
endpackage : umd_pkg

// ---- design/umd_pin_logic.sv ----
// Modem status, request-to-send, serial output idle state and DMA ready signalling of a serial element.
// Assumes a framing engine beside it that delivers received characters and takes characters to send,
// and a host that keeps every bus input synchronous to clock_in.
`timescale 1ns/10ps
`default_nettype none
`include "umd_regs.svh"

// Summary of operation
// [R1] - Modem status bit 6 shows ring input
// [R2] - Ring rising edge sets sticky bit 2
// [R3] - Ring edge raises interrupt when enabled
// [R4] - Control bit 1 set drives request active
// [R5] - Request inactive on reset, loop, clear
// [R6] - FIFO mode: bit 3 selects DMA mode
// [R7] - Non-FIFO mode uses DMA mode 0 only
// [R8] - Mode 0: receive ready low while data
// [R9] - Mode 1: low at trigger, high empty
// [R10] - Serial output marks after master reset
// [R11] - Mode 0 gives single transfers per cycle
// [R12] - Mode 1 transmit ready until FIFO full
// [R13] - Either write strobe polarity writes register
// [R14] - Host holds its unused strobe inactive
// [R15] - Master reset clears registers, output states
// [R16] - Either read strobe polarity reads register
// [R17] - Mode 0: transmit ready low while empty
// [R18] - Modem status read clears ring flag
module umd_pin_logic
   import umd_pkg::*;
#(
   parameter int DEPTH = 16
) (
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       master_reset_in,
   input  wire logic       chip_select_in,
   input  wire logic [3:0] address_in,
   input  wire logic [7:0] write_data_in,
   input  wire logic       write_strobe_low_in,
   input  wire logic       write_strobe_high_in,
   input  wire logic       read_strobe_low_in,
   input  wire logic       read_strobe_high_in,
   input  wire logic       ring_ind_n_in,
   input  wire logic       serial_in,
   input  wire logic       tx_bit_in,
   input  wire logic       rx_char_valid_in,
   input  wire logic [7:0] rx_char_in,
   input  wire logic       rx_timeout_in,
   input  wire logic       tx_char_take_in,
   output logic      [7:0] read_data_out,
   output logic            rts_n_out,
   output logic            serial_out,
   output logic            receive_ready_out,
   output logic            transmit_ready_out,
   output logic            tx_char_valid_out,
   output logic      [7:0] tx_char_out,
   output logic            loop_data_out,
   output logic            irq_out
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
   localparam logic [CW-1:0] ONE_COUNT  = CW'(1);

   // ****************************************************************
   // Register access decode
   // ****************************************************************

   function automatic logic hit(input logic [3:0] addr, input logic [3:0] offset);
      hit = (addr == offset);
   endfunction : hit

   wire       write_en = chip_select_in & (~write_strobe_low_in | write_strobe_high_in);   // [R13]
   wire       read_en  = chip_select_in & (~read_strobe_low_in | read_strobe_high_in);     // [R16]
   wire       wr_data  = write_en & hit(address_in, `UMD_OFS_DATA);
   wire       wr_mask  = write_en & hit(address_in, `UMD_OFS_IRQ_MASK);
   wire       wr_fcr   = write_en & hit(address_in, `UMD_OFS_FIFO_CTL);
   wire       wr_mcr   = write_en & hit(address_in, `UMD_OFS_MODEM_CTL);
   wire       rd_data  = read_en & hit(address_in, `UMD_OFS_DATA);
   wire       rd_msr   = read_en & hit(address_in, `UMD_OFS_MODEM_STS);
   wire       rd_isr   = read_en & hit(address_in, `UMD_OFS_IRQ_STS);

   // ****************************************************************
   // Control registers
   // ****************************************************************

   umd_byte_t fifo_ctl;
   umd_byte_t modem_control_reg;
   logic [2:0] irq_mask;

   wire fifo_enable_bit     = fifo_ctl[`UMD_FCR_FIFO_EN];
   wire dma_mode_select_bit = fifo_ctl[`UMD_FCR_DMA_SEL];
   wire loop_mode           = modem_control_reg[`UMD_MCR_LOOP];
   // Legacy character mode forces single-transfer signalling whatever the select bit holds.
   umd_dma_mode_t dma_mode;
   assign dma_mode = (fifo_enable_bit & dma_mode_select_bit) ? UMD_DMA_MULTI : UMD_DMA_SINGLE;  // [R6] [R7]

   wire [1:0] trig_code = fifo_ctl[`UMD_FCR_TRIG_HI:`UMD_FCR_TRIG_LO];
   wire [7:0] trig_level = (trig_code == 2'h0) ? `UMD_TRIG_0 :
                           (trig_code == 2'h1) ? `UMD_TRIG_1 :
                           (trig_code == 2'h2) ? `UMD_TRIG_2 : `UMD_TRIG_3;
   wire       fifo_clear_rx = wr_fcr & write_data_in[`UMD_FCR_RX_CLR];
   wire       fifo_clear_tx = wr_fcr & write_data_in[`UMD_FCR_TX_CLR];

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fifo_ctl          <= `UMD_RST_FIFO_CTL;
         modem_control_reg <= `UMD_RST_MODEM_CTL;
         irq_mask          <= `UMD_RST_IRQ_MASK;
      end else if (master_reset_in) begin   // [R15]
         fifo_ctl          <= `UMD_RST_FIFO_CTL;
         modem_control_reg <= `UMD_RST_MODEM_CTL;
         irq_mask          <= `UMD_RST_IRQ_MASK;
      end else begin
         if (wr_fcr) begin
            fifo_ctl <= write_data_in;
         end
         if (wr_mcr) begin
            modem_control_reg <= write_data_in;
         end
         if (wr_mask) begin
            irq_mask <= write_data_in[2:0];
         end
      end
   end

   // ****************************************************************
   // Receive and transmit character stores
   // ****************************************************************

   // Without FIFO mode each store behaves as a single holding register.
   umd_byte_t         rx_mem [DEPTH];
   umd_byte_t         tx_mem [DEPTH];
   logic [PW-1:0]     rx_rd, rx_wr, tx_rd, tx_wr;
   logic [CW-1:0]     rx_count, tx_count;

   wire [CW-1:0] capacity = fifo_enable_bit ? FULL_COUNT : ONE_COUNT;
   wire          rx_push  = rx_char_valid_in & (rx_count < capacity);
   wire          rx_pop   = rd_data & (rx_count != '0);
   wire          tx_push  = wr_data & (tx_count < capacity);
   wire          tx_pop   = tx_char_take_in & tx_char_valid_out;

   wire [CW-1:0] next_rx_count = fifo_clear_rx ? '0 :
                                 rx_count + CW'(rx_push) - CW'(rx_pop);
   wire [CW-1:0] next_tx_count = fifo_clear_tx ? '0 :
                                 tx_count + CW'(tx_push) - CW'(tx_pop);
   wire [PW-1:0] next_tx_rd    = fifo_clear_tx ? '0 : tx_rd + PW'(tx_pop);
   wire [PW-1:0] next_tx_wr    = fifo_clear_tx ? '0 : tx_wr + PW'(tx_push);
   // A write into an empty store must reach the output in the same edge as the push.
   wire          tx_bypass     = tx_push & (next_tx_rd == tx_wr);
   wire [7:0]    next_tx_char  = tx_bypass ? write_data_in : tx_mem[next_tx_rd];

   always_ff @(posedge clock_in) begin
      if (rx_push) begin
         rx_mem[rx_wr] <= rx_char_in;
      end
      if (tx_push) begin
         tx_mem[tx_wr] <= write_data_in;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_rd    <= '0;
         rx_wr    <= '0;
         rx_count <= '0;
         tx_rd    <= '0;
         tx_wr    <= '0;
         tx_count <= '0;
      end else if (master_reset_in) begin   // [R15]
         rx_rd    <= '0;
         rx_wr    <= '0;
         rx_count <= '0;
         tx_rd    <= '0;
         tx_wr    <= '0;
         tx_count <= '0;
      end else begin
         rx_rd    <= fifo_clear_rx ? '0 : rx_rd + PW'(rx_pop);
         rx_wr    <= fifo_clear_rx ? '0 : rx_wr + PW'(rx_push);
         rx_count <= next_rx_count;
         tx_rd    <= next_tx_rd;
         tx_wr    <= next_tx_wr;
         tx_count <= next_tx_count;
      end
   end

   // ****************************************************************
   // DMA ready signalling
   // ****************************************************************

   wire rx_at_trigger = ({{(8 - CW){1'b0}}, next_rx_count} >= trig_level) | rx_timeout_in;
   wire rx_empty_next = (next_rx_count == '0);
   wire tx_empty_next = (next_tx_count == '0);
   wire tx_full_next  = (next_tx_count >= capacity);

   // Mode 0 follows the store level each cycle, so one transfer is granted per bus cycle.
   // Mode 1 holds its level between the two thresholds, so a burst runs to empty or full.
   wire next_receive_ready = (dma_mode == UMD_DMA_SINGLE) ? rx_empty_next :              // [R8] [R11]
                             (rx_empty_next ? 1'b1 :
                              (rx_at_trigger ? 1'b0 : receive_ready_out));                // [R9]
   wire next_transmit_ready = (dma_mode == UMD_DMA_SINGLE) ? ~tx_empty_next :            // [R17] [R11]
                              (tx_full_next ? 1'b1 :
                               (tx_empty_next ? 1'b0 : transmit_ready_out));              // [R12]

   // ****************************************************************
   // Modem status, interrupts and pins
   // ****************************************************************

   logic ring_pin_prev;
   logic ring_trailing_edge_flag;
   logic [2:0] irq_status;

   wire ring_trailing_edge = ~ring_pin_prev & ring_ind_n_in;                              // [R2]
   wire [2:0] irq_events;
   assign irq_events[`UMD_IRQ_MODEM]    = ring_trailing_edge;                             // [R3]
   assign irq_events[`UMD_IRQ_RX]       = rx_push;
   assign irq_events[`UMD_IRQ_TX_EMPTY] = tx_pop & (tx_count == ONE_COUNT);

   // A new event in the clearing read's cycle survives the clear.
   wire       next_ring_flag  = ring_trailing_edge | (ring_trailing_edge_flag & ~rd_msr); // [R2] [R18]
   wire [2:0] next_irq_status = irq_events | (irq_status & {3{~rd_isr}});
   wire       next_irq        = |(next_irq_status & irq_mask);                            // [R3]

   wire [7:0] modem_status = {1'b0, ~ring_ind_n_in, 3'h0, ring_trailing_edge_flag, 2'h0}; // [R1]
   wire [7:0] read_mux =
      rd_data ? (rx_count != '0 ? rx_mem[rx_rd] : 8'h00) :
      (read_en & hit(address_in, `UMD_OFS_IRQ_MASK))  ? {5'h00, irq_mask} :
      (read_en & hit(address_in, `UMD_OFS_FIFO_CTL))  ? fifo_ctl :
      (read_en & hit(address_in, `UMD_OFS_MODEM_CTL)) ? modem_control_reg :
      rd_msr ? modem_status :
      rd_isr ? {5'h00, irq_status} :
      (read_en & hit(address_in, `UMD_OFS_LEVELS))    ? {3'h0, rx_count[CW-1:0] & 5'h1f} :
      8'h00;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ring_pin_prev           <= 1'b1;
         ring_trailing_edge_flag <= 1'b0;
         irq_status              <= 3'h0;
         irq_out                 <= 1'b0;
         read_data_out           <= 8'h00;
         rts_n_out               <= 1'b1;
         serial_out              <= 1'b1;
         loop_data_out           <= 1'b1;
         receive_ready_out       <= 1'b1;
         transmit_ready_out      <= 1'b0;
         tx_char_valid_out       <= 1'b0;
         tx_char_out             <= 8'h00;
      end else if (master_reset_in) begin   // [R15]
         ring_pin_prev           <= 1'b1;
         ring_trailing_edge_flag <= 1'b0;
         irq_status              <= 3'h0;
         irq_out                 <= 1'b0;
         read_data_out           <= 8'h00;
         rts_n_out               <= 1'b1;   // [R5]
         serial_out              <= 1'b1;   // [R10]
         loop_data_out           <= 1'b1;
         receive_ready_out       <= 1'b1;
         transmit_ready_out      <= 1'b0;
         tx_char_valid_out       <= 1'b0;
         tx_char_out             <= 8'h00;
      end else begin
         ring_pin_prev           <= ring_ind_n_in;
         ring_trailing_edge_flag <= next_ring_flag;
         irq_status              <= next_irq_status;
         irq_out                 <= next_irq;
         read_data_out           <= read_mux;
         rts_n_out               <= loop_mode | ~modem_control_reg[`UMD_MCR_RTS];    // [R4] [R5]
         // In loop mode the line idles at mark and the engine's bit turns back internally.
         serial_out              <= loop_mode | tx_bit_in;
         loop_data_out           <= loop_mode ? tx_bit_in : serial_in;
         receive_ready_out       <= next_receive_ready;
         transmit_ready_out      <= next_transmit_ready;
         tx_char_valid_out       <= ~tx_empty_next;
         tx_char_out             <= next_tx_char;
      end
   end

endmodule : umd_pin_logic
`default_nettype wire

// ---- dv/umd_checker.sv ----
// Concurrent checks on the ports of the modem, DMA and pin logic.
// Assumes one strobe per bus cycle and rst_n_in as the only asynchronous reset of the single clock domain.
`timescale 1ns/10ps
`default_nettype none
module umd_checker (
   input wire logic       clock_in,
   input wire logic       rst_n_in,
   input wire logic       master_reset_in,
   input wire logic       chip_select_in,
   input wire logic [3:0] address_in,
   input wire logic [7:0] write_data_in,
   input wire logic       write_strobe_low_in,
   input wire logic       write_strobe_high_in,
   input wire logic       read_strobe_low_in,
   input wire logic       read_strobe_high_in,
   input wire logic       ring_ind_n_in,
   input wire logic [7:0] read_data_out,
   input wire logic       rts_n_out,
   input wire logic       serial_out,
   input wire logic       receive_ready_out,
   input wire logic       transmit_ready_out,
   input wire logic       irq_out
);
   wire wr  = chip_select_in & (!write_strobe_low_in | write_strobe_high_in);
   wire rd  = chip_select_in & (!read_strobe_low_in | read_strobe_high_in);
   wire rd6 = rd & (address_in == 4'h6);
   wire wr4 = wr & (address_in == 4'h4);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   a_ring_level: assert property (rd6 && $stable(ring_ind_n_in) |=> read_data_out[6] == !$past(ring_ind_n_in))
      else $error("ring level bit wrong");
   a_ring_edge_flag: assert property ($rose(ring_ind_n_in) ##1 rd6 |=> read_data_out[2])
      else $error("ring edge flag missing");
   a_flag_read_clear: assert property ((rd6 && $stable(ring_ind_n_in)) ##1 (rd6 && $stable(ring_ind_n_in))
      |=> !read_data_out[2]) else $error("ring flag not cleared by read");
   a_rts_set_active: assert property (wr4 && write_data_in[1] && !write_data_in[4] |-> ##[1:2] !rts_n_out)
      else $error("request not active");
   a_rts_clear_idle: assert property (wr4 && !write_data_in[1] |-> ##[1:2] rts_n_out)
      else $error("request not inactive");
   a_loop_forces_idle: assert property (wr4 && write_data_in[4] ##1 (!wr) [*2] |-> serial_out && rts_n_out)
      else $error("loop mode outputs not idle");
   a_master_defaults: assert property (master_reset_in |=> serial_out && rts_n_out && receive_ready_out
      && !transmit_ready_out && !irq_out) else $error("master reset output states wrong");
   a_read_idle_zero: assert property (!rd |=> read_data_out == 8'h00)
      else $error("read data outside read cycle");
   c_ring_rise: cover property ($rose(ring_ind_n_in));
   c_loop_write: cover property (wr4 && write_data_in[4]);
   c_rx_ready: cover property ($fell(receive_ready_out));
endmodule : umd_checker
bind umd_pin_logic umd_checker u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in), .master_reset_in(master_reset_in),
   .chip_select_in(chip_select_in), .address_in(address_in), .write_data_in(write_data_in),
   .write_strobe_low_in(write_strobe_low_in), .write_strobe_high_in(write_strobe_high_in),
   .read_strobe_low_in(read_strobe_low_in), .read_strobe_high_in(read_strobe_high_in),
   .ring_ind_n_in(ring_ind_n_in), .read_data_out(read_data_out), .rts_n_out(rts_n_out), .serial_out(serial_out),
   .receive_ready_out(receive_ready_out), .transmit_ready_out(transmit_ready_out), .irq_out(irq_out));
`default_nettype wire

// ---- dv/umd_partner.sv ----
// Behavioural framing engine and line on the far side of the pin logic.
// Assumes the bench stalls it through stall_in to let the transmit store fill.
`timescale 1ns/10ps
`default_nettype none
module umd_partner (
   input  wire logic clock_in,
   input  wire logic stall_in,
   input  wire logic tx_char_valid_in,
   output logic      tx_char_take_out,
   output logic      tx_bit_out,
   output logic      line_out
);
   logic [3:0] pattern = 4'h0;
   // The line bits keep moving so a stale value is never mistaken for a fresh one.
   always_ff @(posedge clock_in) begin
      pattern <= pattern + 4'h1;
   end
   assign tx_char_take_out = tx_char_valid_in & !stall_in;
   assign tx_bit_out       = pattern[0];
   assign line_out         = pattern[1];
endmodule : umd_partner
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the modem, DMA and pin logic.
// Assumes the checker is bound from its own file and the partner takes characters unless stalled.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h seen %h", nm, e, g); end end
module testbench;
   import umd_pkg::*;
   logic clock_in = 1'b0, rst_n_in = 1'b0, master_reset_in = 1'b0, chip_select_in = 1'b1, stall = 1'b1;
   logic [3:0] address_in = 4'h0;
   logic [7:0] write_data_in = 8'h00, rx_char_in = 8'h00, rd_v, rd_first, tx_char_out, read_data_out;
   logic write_strobe_low_in = 1'b1, write_strobe_high_in = 1'b0, read_strobe_low_in = 1'b1;
   logic read_strobe_high_in = 1'b0, ring_ind_n_in = 1'b1, rx_char_valid_in = 1'b0, rx_timeout_in = 1'b0;
   logic serial_in, tx_bit_in, tx_char_take_in, rts_n_out, serial_out, receive_ready_out, transmit_ready_out;
   logic tx_char_valid_out, loop_data_out, irq_out;
   int n_errors = 0, checks = 0;
   always #2.5 clock_in = ~clock_in;
   umd_pin_logic #(.DEPTH(16)) DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .master_reset_in(master_reset_in),
      .chip_select_in(chip_select_in), .address_in(address_in), .write_data_in(write_data_in),
      .write_strobe_low_in(write_strobe_low_in), .write_strobe_high_in(write_strobe_high_in),
      .read_strobe_low_in(read_strobe_low_in), .read_strobe_high_in(read_strobe_high_in),
      .ring_ind_n_in(ring_ind_n_in), .serial_in(serial_in), .tx_bit_in(tx_bit_in),
      .rx_char_valid_in(rx_char_valid_in), .rx_char_in(rx_char_in), .rx_timeout_in(rx_timeout_in),
      .tx_char_take_in(tx_char_take_in), .read_data_out(read_data_out), .rts_n_out(rts_n_out),
      .serial_out(serial_out), .receive_ready_out(receive_ready_out), .transmit_ready_out(transmit_ready_out),
      .tx_char_valid_out(tx_char_valid_out), .tx_char_out(tx_char_out), .loop_data_out(loop_data_out),
      .irq_out(irq_out));
   umd_partner u_far (.clock_in(clock_in), .stall_in(stall), .tx_char_valid_in(tx_char_valid_out),
      .tx_char_take_out(tx_char_take_in), .tx_bit_out(tx_bit_in), .line_out(serial_in));
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : tick
   // The hi argument picks the active-high strobe, otherwise the active-low one is pulsed.
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input bit hi);
      @(posedge clock_in);
      address_in <= a;
      write_data_in <= d;
      if (hi) write_strobe_high_in <= 1'b1; else write_strobe_low_in <= 1'b0;
      @(posedge clock_in);
      write_strobe_high_in <= 1'b0;
      write_strobe_low_in <= 1'b1;
   endtask : wr
   task automatic rd(input logic [3:0] a, input bit hi);
      @(posedge clock_in);
      address_in <= a;
      if (hi) read_strobe_high_in <= 1'b1; else read_strobe_low_in <= 1'b0;
      @(posedge clock_in);
      read_strobe_high_in <= 1'b0;
      read_strobe_low_in <= 1'b1;
      #1 rd_v = read_data_out;
   endtask : rd
   // Two reads of one register with the strobe held, so the slave sees them back to back.
   task automatic rd_pair(input logic [3:0] a, output logic [7:0] first);
      @(posedge clock_in);
      address_in <= a;
      read_strobe_low_in <= 1'b0;
      @(posedge clock_in);
      #1 first = read_data_out;
      @(posedge clock_in);
      read_strobe_low_in <= 1'b1;
      #1 rd_v = read_data_out;
   endtask : rd_pair
   task automatic rx(input logic [7:0] c);
      @(posedge clock_in);
      rx_char_valid_in <= 1'b1;
      rx_char_in <= c;
      @(posedge clock_in);
      rx_char_valid_in <= 1'b0;
   endtask : rx
   task automatic t_ring;
      @(posedge clock_in) ring_ind_n_in <= 1'b0;
      tick(3);
      rd(4'h6, 1'b1); `CHK("ring level", 1'b1, rd_v[6])
      wr(4'h1, 8'h01, 1'b1);
      ring_ind_n_in <= 1'b1;
      tick(3); `CHK("ring irq", 1'b1, irq_out)
      rd_pair(4'h6, rd_first); `CHK("ring flag", 1'b1, rd_first[2])
      `CHK("flag cleared", 1'b0, rd_v[2])
      rd(4'h8, 1'b0); `CHK("irq cause", 1'b1, rd_v[0])
      tick(2); `CHK("irq released", 1'b0, irq_out)
      wr(4'h1, 8'h00, 1'b0);
      ring_ind_n_in <= 1'b0;
      tick(2);
      @(posedge clock_in) ring_ind_n_in <= 1'b1;
      tick(3); `CHK("masked irq", 1'b0, irq_out)
      rd(4'h8, 1'b0);
   endtask : t_ring
   task automatic t_rts;
      wr(4'h4, 8'h02, 1'b0); tick(2); `CHK("rts set", 1'b0, rts_n_out)
      wr(4'h4, 8'h12, 1'b1); tick(2); `CHK("rts loop", 1'b1, rts_n_out)
      `CHK("serial_out loop", 1'b1, serial_out)
      // The partner's bit toggles every cycle, so the bit taken at the last edge is the inverse of today's.
      `CHK("loop data", ~tx_bit_in, loop_data_out)
      wr(4'h4, 8'h00, 1'b0); tick(2); `CHK("rts clear", 1'b1, rts_n_out)
   endtask : t_rts
   task automatic t_mode0;
      wr(4'h2, 8'h08, 1'b0);
      rx(8'h5a); tick(2); `CHK("rx ready m0", 1'b0, receive_ready_out)
      rd(4'h0, 1'b0); `CHK("rx char", 8'h5a, rd_v)
      tick(1); `CHK("rx empty m0", 1'b1, receive_ready_out)
      @(posedge clock_in) stall <= 1'b1;
      tick(1); `CHK("tx empty m0", 1'b0, transmit_ready_out)
      wr(4'h0, 8'ha5, 1'b1); tick(2); `CHK("tx full m0", 1'b1, transmit_ready_out)
      `CHK("tx char", 8'ha5, tx_char_out)
      `CHK("tx valid", 1'b1, tx_char_valid_out)
      @(posedge clock_in) stall <= 1'b0;
      tick(3); `CHK("tx taken m0", 1'b0, transmit_ready_out)
      `CHK("tx valid gone", 1'b0, tx_char_valid_out)
   endtask : t_mode0
   task automatic t_mode1;
      wr(4'h2, 8'h49, 1'b0);
      for (int i = 0; i < 3; i++) rx(8'(i));
      tick(2); `CHK("below trigger", 1'b1, receive_ready_out)
      rx(8'h03); tick(2); `CHK("at trigger", 1'b0, receive_ready_out)
      for (int i = 0; i < 3; i++) rd(4'h0, 1'b0);
      tick(1); `CHK("ready holds", 1'b0, receive_ready_out)
      rd(4'h0, 1'b1); tick(1); `CHK("rx drained", 1'b1, receive_ready_out)
      rx(8'h11); @(posedge clock_in) rx_timeout_in <= 1'b1;
      @(posedge clock_in) rx_timeout_in <= 1'b0;
      tick(2); `CHK("timeout ready", 1'b0, receive_ready_out)
      rd(4'h0, 1'b0); tick(1); `CHK("timeout drained", 1'b1, receive_ready_out)
      @(posedge clock_in) stall <= 1'b1;
      for (int i = 0; i < 15; i++) wr(4'h0, 8'(i), 1'b0);
      tick(2); `CHK("tx not full", 1'b0, transmit_ready_out)
      wr(4'h0, 8'h0f, 1'b1); tick(2); `CHK("tx full m1", 1'b1, transmit_ready_out)
      @(posedge clock_in) stall <= 1'b0;
      tick(20); `CHK("tx drained m1", 1'b0, transmit_ready_out)
   endtask : t_mode1
   task automatic t_mreset;
      wr(4'h4, 8'h02, 1'b0);
      @(posedge clock_in) master_reset_in <= 1'b1;
      @(posedge clock_in) master_reset_in <= 1'b0;
      #1 `CHK("mr rts", 1'b1, rts_n_out)
      `CHK("mr serial_out", 1'b1, serial_out)
   endtask : t_mreset
   task automatic complete_run;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   initial begin
      tick(10);
      @(posedge clock_in) rst_n_in <= 1'b1;
      #1 `CHK("reset serial_out", 1'b1, serial_out)
      `CHK("reset tx ready", 1'b0, transmit_ready_out)
      t_ring();
      t_rts();
      t_mode0();
      t_mode1();
      t_mreset();
      complete_run();
   end
   // A hang anywhere is cut short here and counted against the run.
   initial begin
      repeat (20000) @(posedge clock_in);
      n_errors++;
      complete_run();
   end
endmodule : testbench
`default_nettype wire
